/* File: hdl/agc_regs.vh */
// Register offsets, field codes, reset values and timing counts of the converter and line controller.
`ifndef AGC_REGS_VH
`define AGC_REGS_VH
`define AGC_ADDR_W 4
`define AGC_REG_LINE_DIR 4'h0
`define AGC_REG_LINE_OUT 4'h1
`define AGC_REG_LINE_POL 4'h2
`define AGC_REG_LINE_IN 4'h3
`define AGC_REG_LINE_SEL 4'h4
`define AGC_REG_LINE_LEVEL 4'h5
`define AGC_REG_LINE_DIRSET 4'h6
`define AGC_REG_AN_RANGE 4'h7
`define AGC_REG_AN_START 4'h8
`define AGC_REG_AN_STATUS 4'h9
`define AGC_REG_AN_RESULT 4'ha
`define AGC_REG_VARIANT 4'hb
`define AGC_REG_AN_DIFF 4'hc
`define AGC_DIR_RESET 3'h7
`define AGC_OUT_RESET 3'h7
`define AGC_POL_RESET 3'h0
`define AGC_DIFF_RESET 4'h0
`define AGC_DIRECTION_IN_CODE 8'h01
`define AGC_DIRECTION_OUT_CODE 8'h00
`define AGC_LINE_LEVEL_LOW_CODE 8'h00
`define AGC_LINE_LEVEL_HIGH_CODE 8'h01
`define AGC_DIGITAL_LINE_SELECT_ONE 8'h90
`define AGC_DIGITAL_LINE_SELECT_TWO 8'h91
`define AGC_DIGITAL_LINE_SELECT_THREE 8'h92
`define AGC_ANALOG_SELECT_ONE 8'h0e
`define AGC_ANALOG_SELECT_TWO 8'h4e
`define AGC_ANALOG_SELECT_THREE 8'h1e
`define AGC_ANALOG_SELECT_FOUR 8'h5e
`define AGC_ANALOG_SELECT_FIVE 8'h2e
`define AGC_ANALOG_SELECT_SIX 8'h6e
`define AGC_ANALOG_SELECT_SEVEN 8'h3e
`define AGC_ANALOG_SELECT_EIGHT 8'h7e
`define AGC_RANGE_BIPOLAR_FIVE 8'h00
`define AGC_RANGE_BIPOLAR_TEN 8'h04
`define AGC_RANGE_UNIPOLAR_FIVE 8'h08
`define AGC_RANGE_UNIPOLAR_TEN 8'h0c
`define AGC_RANGE_MASK 8'h0c
`define AGC_VARIANT_TWELVE_BIT 8'h01
`define AGC_VARIANT_SIXTEEN_BIT 8'h02
`define AGC_CLK_HZ 25000000
`define AGC_ACQ_TIME_NS 4000
`define AGC_SAMPLE_RATE_SPS 100000
`define AGC_ACQ_CYCLES ((`AGC_ACQ_TIME_NS * (`AGC_CLK_HZ / 1000000) + 999) / 1000)
`define AGC_PERIOD_CYCLES ((`AGC_CLK_HZ + `AGC_SAMPLE_RATE_SPS - 1) / `AGC_SAMPLE_RATE_SPS)
`define AGC_SCLK_DIV 2
`endif

/* File: hdl/agc_top.v */
// Host-facing controller for an eight-channel converter and three digital lines.
`timescale 1ns/1ps
`default_nettype none
`include "agc_regs.vh"
module agc_top #(
  parameter SIXTEEN_BIT = 1,
  parameter ACQ_CYCLES = `AGC_ACQ_CYCLES,
  parameter PERIOD_CYCLES = `AGC_PERIOD_CYCLES
) (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Register port.
  input wire [`AGC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_ff,
  // Digital lines, one bit per line.
  input wire [2:0] line_in,
  output reg [2:0] line_out_ff,
  output reg [2:0] line_oe_ff,
  output reg [2:0] line_pullup_ff,
  // Converter serial port.
  output reg adc_cs_n_ff,
  output reg adc_sclk_ff,
  output reg adc_mosi_ff,
  input wire adc_miso
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ACQ = 2'h1;
  localparam ST_XFER = 2'h2;
  localparam ST_GAP = 2'h3;
  localparam RES_W = SIXTEEN_BIT ? 16 : 12;

  // Maps a channel select code to its index; bit 3 flags an unknown code.
  function [3:0] analog_index;
    input [7:0] code;
    begin
      case (code)
        `AGC_ANALOG_SELECT_ONE: analog_index = 4'h0;
        `AGC_ANALOG_SELECT_TWO: analog_index = 4'h1;
        `AGC_ANALOG_SELECT_THREE: analog_index = 4'h2;
        `AGC_ANALOG_SELECT_FOUR: analog_index = 4'h3;
        `AGC_ANALOG_SELECT_FIVE: analog_index = 4'h4;
        `AGC_ANALOG_SELECT_SIX: analog_index = 4'h5;
        `AGC_ANALOG_SELECT_SEVEN: analog_index = 4'h6;
        `AGC_ANALOG_SELECT_EIGHT: analog_index = 4'h7;
        default: analog_index = 4'h8;
      endcase
    end
  endfunction

  function [7:0] analog_code;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: analog_code = `AGC_ANALOG_SELECT_ONE;
        3'h1: analog_code = `AGC_ANALOG_SELECT_TWO;
        3'h2: analog_code = `AGC_ANALOG_SELECT_THREE;
        3'h3: analog_code = `AGC_ANALOG_SELECT_FOUR;
        3'h4: analog_code = `AGC_ANALOG_SELECT_FIVE;
        3'h5: analog_code = `AGC_ANALOG_SELECT_SIX;
        3'h6: analog_code = `AGC_ANALOG_SELECT_SEVEN;
        default: analog_code = `AGC_ANALOG_SELECT_EIGHT;
      endcase
    end
  endfunction

  // Maps a line select code to a one-hot line mask; zero for an unknown code.
  function [2:0] line_mask;
    input [7:0] code;
    begin
      case (code)
        `AGC_DIGITAL_LINE_SELECT_ONE: line_mask = 3'h1;
        `AGC_DIGITAL_LINE_SELECT_TWO: line_mask = 3'h2;
        `AGC_DIGITAL_LINE_SELECT_THREE: line_mask = 3'h4;
        default: line_mask = 3'h0;
      endcase
    end
  endfunction

  reg [2:0] pin_meta_ff;
  reg [2:0] pin_sync_ff;
  reg miso_meta_ff;
  reg miso_sync_ff;
  reg [2:0] dir_in_ff;
  reg [2:0] pol_inv_ff;
  reg [2:0] sel_mask_ff;
  reg [7:0] range_ff [0:7];
  reg [3:0] diff_ff;
  reg [2:0] chan_ff;
  reg [1:0] state_ff;
  reg [9:0] acq_cnt_ff;
  reg [9:0] period_cnt_ff;
  reg [4:0] bit_cnt_ff;
  reg [15:0] shift_out_ff;
  reg [15:0] shift_in_ff;
  reg [15:0] result_ff;
  reg busy_ff;
  reg done_ff;
  reg [3:0] div_cnt_ff;
  wire [2:0] line_level;
  wire [3:0] wr_idx;
  wire [7:0] adc_cmd;
  wire sclk_tick;
  integer i;

  // Reported level: synchronised pin, flipped when polarity is inverted.
  assign line_level = pin_sync_ff ^ pol_inv_ff;
  assign wr_idx = analog_index(reg_wdata);
  // Command byte: channel code, its range bits, and bit 0 flipped for a differential pair.
  assign adc_cmd = (analog_code(chan_ff) | (range_ff[chan_ff] & `AGC_RANGE_MASK)) ^
                   {7'h00, diff_ff[chan_ff[2:1]]};
  assign sclk_tick = (div_cnt_ff == (`AGC_SCLK_DIV - 1));

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
      miso_meta_ff <= 1'b0;
      miso_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= line_in;
      pin_sync_ff <= pin_meta_ff;
      miso_meta_ff <= adc_miso;
      miso_sync_ff <= miso_meta_ff;
    end
  end

  // Line configuration and pin drivers.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_in_ff <= `AGC_DIR_RESET;
      line_out_ff <= `AGC_OUT_RESET;
      line_oe_ff <= 3'h0;
      line_pullup_ff <= 3'h7;
      pol_inv_ff <= `AGC_POL_RESET;
      sel_mask_ff <= 3'h1;
      diff_ff <= `AGC_DIFF_RESET;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `AGC_REG_LINE_DIR: dir_in_ff <= reg_wdata[2:0];
          `AGC_REG_LINE_OUT: line_out_ff <= reg_wdata[2:0];
          `AGC_REG_LINE_POL: pol_inv_ff <= reg_wdata[2:0];
          `AGC_REG_LINE_SEL: sel_mask_ff <= line_mask(reg_wdata);
          `AGC_REG_LINE_LEVEL: begin
            if (reg_wdata == `AGC_LINE_LEVEL_HIGH_CODE) begin
              line_out_ff <= line_out_ff | sel_mask_ff;
            end else if (reg_wdata == `AGC_LINE_LEVEL_LOW_CODE) begin
              line_out_ff <= line_out_ff & ~sel_mask_ff;
            end
          end
          `AGC_REG_LINE_DIRSET: begin
            if (reg_wdata == `AGC_DIRECTION_IN_CODE) begin
              dir_in_ff <= dir_in_ff | sel_mask_ff;
            end else if (reg_wdata == `AGC_DIRECTION_OUT_CODE) begin
              dir_in_ff <= dir_in_ff & ~sel_mask_ff;
            end
          end
          `AGC_REG_AN_DIFF: diff_ff <= reg_wdata[3:0];
          default: begin
          end
        endcase
      end
      line_oe_ff <= ~dir_in_ff;
      line_pullup_ff <= dir_in_ff;
    end
  end

  // Per-channel range store; write data is {channel code} then {8'h80 | range} latched via index.
  reg [2:0] range_sel_ff;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      range_sel_ff <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        range_ff[i] <= `AGC_RANGE_BIPOLAR_FIVE;
      end
    end else if (reg_wr && reg_addr == `AGC_REG_AN_RANGE) begin
      if (!wr_idx[3]) begin
        range_sel_ff <= wr_idx[2:0];
      end else if ((reg_wdata & ~`AGC_RANGE_MASK) == 8'h80) begin
        range_ff[range_sel_ff] <= reg_wdata & `AGC_RANGE_MASK;
      end
    end
  end

  // Conversion sequencer: acquisition, serial transfer, then rate gap.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      chan_ff <= 3'h0;
      acq_cnt_ff <= 10'h000;
      period_cnt_ff <= 10'h000;
      bit_cnt_ff <= 5'h00;
      shift_out_ff <= 16'h0000;
      shift_in_ff <= 16'h0000;
      result_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      div_cnt_ff <= 4'h0;
      adc_cs_n_ff <= 1'b1;
      adc_sclk_ff <= 1'b0;
      adc_mosi_ff <= 1'b0;
    end else begin
      if (period_cnt_ff != 10'h000) begin
        period_cnt_ff <= period_cnt_ff - 10'h001;
      end
      case (state_ff)
        ST_IDLE: begin
          if (reg_wr && reg_addr == `AGC_REG_AN_START && !wr_idx[3]) begin
            chan_ff <= wr_idx[2:0];
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
            acq_cnt_ff <= ACQ_CYCLES[9:0];
            period_cnt_ff <= PERIOD_CYCLES[9:0];
            state_ff <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (acq_cnt_ff <= 10'h001) begin
            shift_out_ff <= {adc_cmd, 8'h00};
            adc_mosi_ff <= adc_cmd[7];
            adc_cs_n_ff <= 1'b0;
            bit_cnt_ff <= 5'h10;
            div_cnt_ff <= 4'h0;
            state_ff <= ST_XFER;
          end else begin
            acq_cnt_ff <= acq_cnt_ff - 10'h001;
          end
        end
        ST_XFER: begin
          div_cnt_ff <= sclk_tick ? 4'h0 : div_cnt_ff + 4'h1;
          if (sclk_tick) begin
            // Command data moves on the falling edge so it is settled before the rise.
            if (!adc_sclk_ff) begin
              adc_sclk_ff <= (bit_cnt_ff != 5'h00);
            end else begin
              adc_sclk_ff <= 1'b0;
              adc_mosi_ff <= shift_out_ff[14];
              shift_out_ff <= {shift_out_ff[14:0], 1'b0};
              shift_in_ff <= {shift_in_ff[14:0], miso_sync_ff};
              bit_cnt_ff <= bit_cnt_ff - 5'h01;
            end
            if (!adc_sclk_ff && bit_cnt_ff == 5'h00) begin
              adc_cs_n_ff <= 1'b1;
              // A twelve-bit part returns its result left-justified.
              result_ff <= shift_in_ff >> (16 - RES_W);
              state_ff <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (period_cnt_ff <= 10'h001) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      if (reg_rd && reg_addr == `AGC_REG_AN_RESULT && state_ff != ST_GAP) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `AGC_REG_LINE_DIR: reg_rdata_ff <= {13'h0000, dir_in_ff};
        `AGC_REG_LINE_OUT: reg_rdata_ff <= {13'h0000, line_out_ff};
        `AGC_REG_LINE_POL: reg_rdata_ff <= {13'h0000, pol_inv_ff};
        `AGC_REG_LINE_IN: reg_rdata_ff <= {13'h0000, line_level};
        `AGC_REG_LINE_SEL: reg_rdata_ff <= {13'h0000, sel_mask_ff};
        `AGC_REG_LINE_LEVEL: reg_rdata_ff <= {15'h0000, |(line_level & sel_mask_ff)};
        `AGC_REG_LINE_DIRSET: reg_rdata_ff <= {15'h0000, |(dir_in_ff & sel_mask_ff)};
        `AGC_REG_AN_RANGE: reg_rdata_ff <= {8'h00, range_ff[range_sel_ff]};
        `AGC_REG_AN_STATUS: reg_rdata_ff <= {11'h000, chan_ff, done_ff, busy_ff};
        `AGC_REG_AN_RESULT: reg_rdata_ff <= result_ff;
        `AGC_REG_VARIANT: reg_rdata_ff <= SIXTEEN_BIT ? {8'h00, `AGC_VARIANT_SIXTEEN_BIT} :
                                          {8'h00, `AGC_VARIANT_TWELVE_BIT};
        `AGC_REG_AN_DIFF: reg_rdata_ff <= {12'h000, diff_ff};
        default: reg_rdata_ff <= 16'h0000;
      endcase
    end else begin
      reg_rdata_ff <= 16'h0000;
    end
  end

endmodule // agc_top
`default_nettype wire

/* File: sim/agc_top_asserts.sv */
// Port checks for the converter and line controller.
`timescale 1ns/1ps
`default_nettype none
module agc_top_asserts #(
  parameter SIXTEEN_BIT = 1,
  parameter ACQ_CYCLES = 100,
  parameter PERIOD_CYCLES = 250
) (
  // Clock, reset and register port.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_ff,
  // Lines and converter port.
  input wire logic [2:0] line_in,
  input wire logic [2:0] line_out_ff,
  input wire logic [2:0] line_oe_ff,
  input wire logic [2:0] line_pullup_ff,
  input wire logic adc_cs_n_ff,
  input wire logic adc_sclk_ff,
  input wire logic adc_mosi_ff,
  input wire logic adc_miso
);
  logic [31:0] gap_cnt;
  logic [4:0] bit_cnt;
  logic sclk_q;
  logic cs_q;
  // Cycles since the last frame began, and serial clock rises in this frame.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt <= 32'h7fff_ffff;
      bit_cnt <= 5'h0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      gap_cnt <= (cs_q && !adc_cs_n_ff) ? 32'h0 : gap_cnt + 32'h1;
      bit_cnt <= adc_cs_n_ff ? 5'h0 : bit_cnt + {4'h0, adc_sclk_ff && !sclk_q};
      sclk_q <= adc_sclk_ff;
      cs_q <= adc_cs_n_ff;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 16'h0)
    else $error("read data not zero outside a read slot");
  variant_read_a: assert property (reg_rd && reg_addr == 4'hb |=>
    reg_rdata_ff == (SIXTEEN_BIT ? 16'h0002 : 16'h0001))
    else $error("wrong variant code");
  unmapped_read_a: assert property (reg_rd && reg_addr > 4'hc |=> reg_rdata_ff == 16'h0)
    else $error("unmapped read not zero");
  pull_vs_drive_a: assert property (line_pullup_ff == ~line_oe_ff)
    else $error("pull-up and drive disagree");
  reset_inputs_a: assert property (!$past(arst_n) |-> line_oe_ff == 3'h0 && line_pullup_ff == 3'h7)
    else $error("lines not inputs after reset");
  line_hold_a: assert property (!$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3)
    |-> $stable(line_out_ff) && $stable(line_oe_ff))
    else $error("line changed without a write");
  sclk_idle_a: assert property (adc_cs_n_ff |-> !adc_sclk_ff)
    else $error("serial clock runs outside a frame");
  sample_period_a: assert property ($fell(adc_cs_n_ff) |-> gap_cnt >= PERIOD_CYCLES - 1)
    else $error("frames closer than the sample period");
  frame_bits_a: assert property ($rose(adc_cs_n_ff) |-> bit_cnt == 5'h10)
    else $error("frame is not sixteen bits");
  cover property ($fell(adc_cs_n_ff));
  cover property (reg_rd && reg_addr == 4'ha);
  cover property ($rose(line_oe_ff[2]));
endmodule // agc_top_asserts
bind agc_top agc_top_asserts #(.SIXTEEN_BIT(SIXTEEN_BIT), .ACQ_CYCLES(ACQ_CYCLES),
  .PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .line_in(line_in), .line_out_ff(line_out_ff), .line_oe_ff(line_oe_ff),
  .line_pullup_ff(line_pullup_ff), .adc_cs_n_ff(adc_cs_n_ff), .adc_sclk_ff(adc_sclk_ff),
  .adc_mosi_ff(adc_mosi_ff), .adc_miso(adc_miso));
`default_nettype wire

/* File: sim/agc_far_model.sv */
// Behavioural converter and external line model.
`timescale 1ns/1ps
`default_nettype none
module agc_far_model (
  // Converter serial port.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output var logic miso,
  output var logic [7:0] cmd,
  input wire logic [15:0] word,
  // Digital lines.
  input wire logic [2:0] out,
  input wire logic [2:0] oe,
  input wire logic [2:0] pull_en,
  input wire logic [2:0] ext_drv,
  input wire logic [2:0] ext_lvl,
  output logic [2:0] pin
);
  logic [15:0] tx = 16'h0;
  logic [15:0] rx = 16'h0;
  initial miso = 1'b0;
  // Own driver first, then the outside driver, then the pull-up.
  assign pin = (oe & out) | (~oe & ext_drv & ext_lvl) | (~oe & ~ext_drv & pull_en);
  always @(negedge cs_n) begin
    tx = word;
    miso = tx[15];
  end
  always @(negedge sclk) begin
    if (!cs_n) begin
      tx = {tx[14:0], 1'b0};
      miso = tx[15];
    end
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      rx = {rx[14:0], mosi};
    end
  end
  // Released data line shows the inverse of its last bit.
  always @(posedge cs_n) begin
    cmd = rx[15:8];
    miso = ~miso;
  end
endmodule // agc_far_model
`default_nettype wire

/* File: sim/agc_top_tb.sv */
// Self-checking bench for the converter and line controller.
`timescale 1ns/1ps
`default_nettype none
module agc_top_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] got;
  logic [15:0] rdata12;
  logic [15:0] got12;
  logic [15:0] word = 16'h0;
  logic [2:0] lin, lout, loe, lpu;
  logic [2:0] ext_lvl = 3'h0;
  logic [2:0] ext_drv = 3'h0;
  logic cs_n, sclk, mosi, miso;
  logic [7:0] cmd;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] codes [8] = '{8'h0e, 8'h4e, 8'h1e, 8'h5e, 8'h2e, 8'h6e, 8'h3e, 8'h7e};
  logic [7:0] rngs [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  always #20 clk = ~clk;
  agc_top #(.ACQ_CYCLES(4), .PERIOD_CYCLES(120)) dut (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(rdata), .line_in(lin), .line_out_ff(lout), .line_oe_ff(loe),
    .line_pullup_ff(lpu), .adc_cs_n_ff(cs_n), .adc_sclk_ff(sclk), .adc_mosi_ff(mosi),
    .adc_miso(miso));
  agc_far_model far (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .cmd(cmd),
    .word(word), .out(lout), .oe(loe), .pull_en(lpu), .ext_drv(ext_drv),
    .ext_lvl(ext_lvl), .pin(lin));
  // Twelve-bit variant on the same bus and converter data, compared on reads only.
  agc_top #(.SIXTEEN_BIT(0), .ACQ_CYCLES(4), .PERIOD_CYCLES(120)) dut_twelve (.clk(clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(rdata12), .line_in(lin), .line_out_ff(),
    .line_oe_ff(), .line_pullup_ff(), .adc_cs_n_ff(), .adc_sclk_ff(), .adc_mosi_ff(),
    .adc_miso(miso));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = rdata;
    got12 = rdata12;
  endtask
  // Starts channel i, checks busy, waits for done, then checks word and command.
  task automatic conv(input int i, input logic [7:0] c);
    word = {codes[i], ~codes[i]};
    wr(4'h8, codes[i]);
    if (i == 1) wr(4'h8, codes[2]);
    rd(4'h9);
    chk("busy", 16'h1, got & 16'h3);
    chk("channel", i[15:0], (got >> 2) & 16'h7);
    for (int n = 0; n < 200 && got[1] !== 1'b1; n++) rd(4'h9);
    rd(4'ha);
    chk("result", {codes[i], ~codes[i]}, got);
    chk("result twelve", {codes[i], ~codes[i]} >> 4, got12);
    chk("command", {8'h0, c}, {8'h0, cmd});
  endtask
  task automatic finish_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk("oe", 16'h0, {13'h0, loe});
    chk("pullup", 16'h7, {13'h0, lpu});
    rd(4'hb);
    chk("variant", 16'h2, got);
    chk("variant twelve", 16'h1, got12);
    rd(4'hd);
    chk("unmapped", 16'h0, got);
    rd(4'h0);
    chk("dir reset", 16'h7, got);
    for (int k = 0; k < 3; k++) begin
      wr(4'h4, 8'h90 + k[7:0]);
      wr(4'h6, 8'h00);
      wr(4'h5, 8'h00);
      // The pin level needs the synchroniser's cycles to reach the read path.
      repeat (3) @(posedge clk);
      rd(4'h5);
      chk("level low", 16'h0, got);
      chk("drive low", 16'h1, {15'h0, loe[k] & ~lout[k]});
      chk("oe mask", (16'h2 << k) - 16'h1, {13'h0, loe});
      wr(4'h5, 8'h01);
      repeat (3) @(posedge clk);
      rd(4'h5);
      chk("level high", 16'h1, got);
      chk("drive high", 16'h1, {15'h0, lout[k]});
    end
    wr(4'h6, 8'h01);
    rd(4'h6);
    chk("dir in", 16'h1, got);
    wr(4'h0, 8'h07);
    ext_drv <= 3'h7;
    ext_lvl <= 3'h5;
    repeat (4) @(posedge clk);
    rd(4'h3);
    chk("pin normal", 16'h5, got);
    wr(4'h2, 8'h03);
    rd(4'h3);
    chk("pin inverted", 16'h6, got);
    for (int i = 0; i < 8; i++) begin
      wr(4'h7, codes[i]);
      wr(4'h7, 8'h80 | rngs[i % 4]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(4'h7, codes[i]);
      rd(4'h7);
      chk("range", {8'h0, rngs[i % 4]}, got);
      conv(i, codes[i] | rngs[i % 4]);
    end
    wr(4'hc, 8'h01);
    conv(0, (codes[0] | rngs[0]) ^ 8'h01);
    finish_test();
  end
endmodule // agc_top_tb
`default_nettype wire
